//--- rtl/sample_buffer_config_control.sv
// Summary of operation
// - Writing one to the flush bit empties the buffer and clears its flags.
// - A flush also pulses clearing of gate error and gate sample count.
// - Flush bit self-clears next cycle and always reads back as zero.
// - Selector at zero: sleep logic ignores watermark and overflow flags.
// - Selector at one: sleep allowed only while those flags remain pending.
// - Host clearing flags by flush or read restarts the sleep timer.
// - Selector matters only in stream or stop buffer modes.
// - Watermark flag rises when stored count reaches the threshold.
// - Threshold of zero never raises the watermark flag.
// - In triggered mode the threshold caps samples kept before the trigger.
// - Flush bit 7, selector bit 6, threshold bits 5..0, all reset zero.
// - Buffer mode off flushes and clears overflow, watermark and count.
// - After trigger: ignore triggers, take capacity minus threshold, set overflow, halt.
`timescale 1ns/1ps
module sample_buffer_config_control
	import sample_buffer_pkg::*;
#(
	parameter int DEPTH = BUF_CAPACITY,
	localparam int CW   = $clog2(DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	// Register port
	input  reg_req_t           reg_req,
	output logic [7:0]         reg_rdata_r,
	// Mode and trigger
	input  wire logic [1:0]    buf_mode,
	input  wire logic          trig_in,
	// Sample source
	input  wire logic          smp_valid,
	output logic               smp_ready_r,
	input  sample_t            smp_data,
	// Sample readout
	input  wire logic          rd_req,
	output logic               rd_valid_r,
	output sample_t            rd_data_r,
	// Status
	output logic [CW-1:0]      sample_count,
	output logic               wmrk_flag_r,
	output logic               queue_overflow_flag_r,
	output logic               gate_clear_r,
	output logic               aslp_restart_r,
	output logic               sleep_permit_r
);

	localparam logic [CW-1:0] FULL_C = CW'(DEPTH);

	logic                fill_flags_hold_awake_r;
	logic                fill_flags_hold_awake_nxt;
	logic [THRESH_W-1:0] fill_threshold_r;
	logic [THRESH_W-1:0] fill_threshold_nxt;
	logic                flush_r;
	logic                flush_nxt;
	logic [7:0]          reg_rdata_nxt;
	trig_state_t         trg_r;
	trig_state_t         trg_nxt;
	logic [CW-1:0]       post_cnt_r;
	logic [CW-1:0]       post_cnt_nxt;
	logic                smp_ready_nxt;
	logic                rd_valid_nxt;
	sample_t             rd_data_nxt;
	logic                wmrk_flag_nxt;
	logic                ovf_nxt;
	logic                gate_clear_nxt;
	logic                aslp_restart_nxt;
	logic                sleep_permit_nxt;
	logic                offer;
	logic                fifo_out_valid;
	logic                fifo_pop;
	logic                push;
	logic                drop;
	logic                host_pop;
	logic                flush_now;
	logic                mode_rel;
	logic                flags_any_nxt;
	logic [CW-1:0]       cnt;
	logic [CW-1:0]       cnt_after;
	logic [CW:0]         thr_ext;
	logic [CW:0]         post_tgt;
	logic [$bits(sample_t)-1:0] fifo_out;

	assign flush_now = flush_r || (buf_mode == MODE_OFF);
	assign mode_rel  = (buf_mode == MODE_STREAM) || (buf_mode == MODE_STOP);
	assign thr_ext   = (CW + 1)'(fill_threshold_r);
	// Threshold above capacity leaves nothing to collect after the trigger
	assign post_tgt  = (thr_ext >= (CW + 1)'(DEPTH)) ? '0 : (CW + 1)'(DEPTH) - thr_ext;

	always_comb
	begin
		// Room judged from our own pop, not the FIFO ready, so no loop forms
		offer    = smp_valid && smp_ready_r && !flush_now;
		drop     = 1'b0;
		if (offer && (buf_mode == MODE_STREAM) && (cnt == FULL_C))
			drop = 1'b1;
		if (offer && (buf_mode == MODE_TRIG) && (trg_r == TRG_PRE) && (cnt != '0)
			&& ((CW + 1)'(cnt) >= thr_ext))
			drop = 1'b1;
		host_pop = rd_req && fifo_out_valid && !flush_now;
		fifo_pop = fifo_out_valid && (host_pop || drop) && !flush_now;
		push     = offer && ((cnt != FULL_C) || fifo_pop);
		cnt_after = cnt;
		if (flush_now)
			cnt_after = '0;
		else if (push && !fifo_pop)
			cnt_after = cnt + 1'b1;
		else if (fifo_pop && !push)
			cnt_after = cnt - 1'b1;
	end

	// Register file
	always_comb
	begin
		flush_nxt                 = 1'b0;
		fill_flags_hold_awake_nxt = fill_flags_hold_awake_r;
		fill_threshold_nxt        = fill_threshold_r;
		reg_rdata_nxt             = 8'h00;
		if (reg_req.wr && (reg_req.addr == BUF_CFG2_ADDR))
		begin
			flush_nxt                 = reg_req.wdata[FLUSH_BIT];
			fill_flags_hold_awake_nxt = reg_req.wdata[HOLD_AWAKE_BIT];
			fill_threshold_nxt        = reg_req.wdata[THRESH_LSB +: THRESH_W];
		end
		if (reg_req.rd && (reg_req.addr == BUF_CFG2_ADDR))
		begin
			reg_rdata_nxt[FLUSH_BIT]                 = 1'b0;
			reg_rdata_nxt[HOLD_AWAKE_BIT]            = fill_flags_hold_awake_r;
			reg_rdata_nxt[THRESH_LSB +: THRESH_W]    = fill_threshold_r;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flush_r                 <= BUF_CFG2_RESET[FLUSH_BIT];
			fill_flags_hold_awake_r <= BUF_CFG2_RESET[HOLD_AWAKE_BIT];
			fill_threshold_r        <= BUF_CFG2_RESET[THRESH_LSB +: THRESH_W];
			reg_rdata_r             <= 8'h00;
		end
		else if (ce)
		begin
			flush_r                 <= flush_nxt;
			fill_flags_hold_awake_r <= fill_flags_hold_awake_nxt;
			fill_threshold_r        <= fill_threshold_nxt;
			reg_rdata_r             <= reg_rdata_nxt;
		end
	end

	// Triggered-mode sequencer
	always_comb
	begin
		trg_nxt      = trg_r;
		post_cnt_nxt = post_cnt_r;
		case (trg_r)
			TRG_PRE:
			begin
				post_cnt_nxt = '0;
				if (trig_in)
					trg_nxt = TRG_POST;
			end
			TRG_POST:
			begin
				// Later triggers are ignored here
				if (push)
					post_cnt_nxt = post_cnt_r + 1'b1;
				// A full store ends capture even if the count falls short
				if (((CW + 1)'(post_cnt_nxt) >= post_tgt) || (cnt_after == FULL_C))
					trg_nxt = TRG_HOLD;
			end
			TRG_HOLD:
			begin
				if (cnt_after == '0)
					trg_nxt = TRG_PRE;
			end
			default:
			begin
				trg_nxt = TRG_PRE;
			end
		endcase
		if (flush_now || (buf_mode != MODE_TRIG))
		begin
			trg_nxt      = TRG_PRE;
			post_cnt_nxt = '0;
		end
	end

	// Flags, readout and wake control
	always_comb
	begin
		smp_ready_nxt = 1'b0;
		if (!flush_nxt && (buf_mode != MODE_OFF) && (trg_nxt != TRG_HOLD))
			smp_ready_nxt = (buf_mode == MODE_STREAM) || (trg_nxt == TRG_PRE
				&& buf_mode == MODE_TRIG) || (cnt_after != FULL_C);
		rd_valid_nxt  = host_pop;
		rd_data_nxt   = host_pop ? sample_t'(fifo_out) : rd_data_r;
		wmrk_flag_nxt = (fill_threshold_r != '0)
			&& ((CW + 1)'(cnt_after) >= thr_ext);
		ovf_nxt       = queue_overflow_flag_r;
		if (flush_now || host_pop)
			ovf_nxt = 1'b0;
		// Set beats a read clear when both land together; a flush clear still wins
		if ((drop && buf_mode == MODE_STREAM)
			|| (buf_mode == MODE_STOP && cnt_after == FULL_C)
			|| (trg_r == TRG_POST && trg_nxt == TRG_HOLD))
			ovf_nxt = 1'b1;
		if (flush_now)
			ovf_nxt = 1'b0;
		gate_clear_nxt   = flush_now || (host_pop && cnt_after == '0);
		flags_any_nxt    = wmrk_flag_nxt || ovf_nxt;
		aslp_restart_nxt = fill_flags_hold_awake_r && mode_rel
			&& (wmrk_flag_r || queue_overflow_flag_r) && !flags_any_nxt
			&& (flush_r || host_pop);
		sleep_permit_nxt = !(fill_flags_hold_awake_r && mode_rel)
			|| flags_any_nxt;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trg_r                 <= TRG_PRE;
			post_cnt_r            <= '0;
			smp_ready_r           <= 1'b0;
			rd_valid_r            <= 1'b0;
			rd_data_r             <= '0;
			wmrk_flag_r           <= 1'b0;
			queue_overflow_flag_r <= 1'b0;
			gate_clear_r          <= 1'b0;
			aslp_restart_r        <= 1'b0;
			sleep_permit_r        <= SLEEP_OK_RESET;
		end
		else if (ce)
		begin
			trg_r                 <= trg_nxt;
			post_cnt_r            <= post_cnt_nxt;
			smp_ready_r           <= smp_ready_nxt;
			rd_valid_r            <= rd_valid_nxt;
			rd_data_r             <= rd_data_nxt;
			wmrk_flag_r           <= wmrk_flag_nxt;
			queue_overflow_flag_r <= ovf_nxt;
			gate_clear_r          <= gate_clear_nxt;
			aslp_restart_r        <= aslp_restart_nxt;
			sleep_permit_r        <= sleep_permit_nxt;
		end
	end

	sample_fifo #(
		.WIDTH     ($bits(sample_t)),
		.DEPTH     (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.flush     (flush_now),
		.in_valid  (push),
		.in_ready  (),
		.in_data   (smp_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out),
		.count     (cnt)
	);

	assign sample_count = cnt;

endmodule

//--- rtl/sample_buffer_pkg.sv
package sample_buffer_pkg;

	// Register map
	localparam logic [7:0] BUF_CFG2_ADDR   = 8'h27;
	localparam logic [7:0] BUF_CFG2_RESET  = 8'h00;
	localparam int         FLUSH_BIT       = 7;
	localparam int         HOLD_AWAKE_BIT  = 6;
	localparam int         THRESH_LSB      = 0;
	localparam int         THRESH_W        = 6;

	// Buffer modes
	localparam logic [1:0] MODE_OFF        = 2'h0;
	localparam logic [1:0] MODE_STREAM     = 2'h1;
	localparam logic [1:0] MODE_STOP       = 2'h2;
	localparam logic [1:0] MODE_TRIG       = 2'h3;

	// Sizes and reset values
	localparam int         BUF_CAPACITY    = 32;
	localparam int         FIFO_DEPTH_DEF  = 16;
	localparam int         AXIS_W          = 12;
	localparam logic       SLEEP_OK_RESET  = 1'b1;

	typedef struct packed {
		logic [AXIS_W-1:0] x;
		logic [AXIS_W-1:0] y;
		logic [AXIS_W-1:0] z;
	} sample_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		TRG_PRE  = 2'b00,
		TRG_POST = 2'b01,
		TRG_HOLD = 2'b11
	} trig_state_t;

endpackage

//--- rtl/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo
	import sample_buffer_pkg::*;
#(
	parameter int WIDTH = 3 * AXIS_W,
	parameter int DEPTH = FIFO_DEPTH_DEF,
	localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	localparam int CW   = $clog2(DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [CW-1:0]         count
);

	localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [CW-1:0]    count_r;
	logic [CW-1:0]    count_nxt;
	logic             push;
	logic             pop;

	// Push at full is allowed only alongside a pop
	assign out_valid = (count_r != '0);
	assign in_ready  = (count_r != FULL_C) || out_ready;
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;
	assign out_data  = mem_r[rd_ptr_r];
	assign count     = count_r;

	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt  = count_r;
		if (flush)
		begin
			wr_ptr_nxt = '0;
			rd_ptr_nxt = '0;
			count_nxt  = '0;
		end
		else
		begin
			if (push)
				wr_ptr_nxt = (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_nxt = (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_nxt = count_r + 1'b1;
			else if (pop && !push)
				count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else if (ce)
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// Storage is not reset; count guards against stale entries
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_entry
		logic [WIDTH-1:0] mem_nxt;
		always_comb
		begin
			mem_nxt = mem_r[i];
			if (push && (wr_ptr_r == AW'(i)))
				mem_nxt = in_data;
		end
		always_ff @(posedge mclk)
		begin
			if (ce)
				mem_r[i] <= mem_nxt;
		end
	end

endmodule

//--- verif/sample_buffer_config_control_assertions.sv
`timescale 1ns/1ps
module sample_buffer_config_control_assertions
	import sample_buffer_pkg::*;
#(
	parameter int DEPTH = BUF_CAPACITY,
	localparam int CW   = $clog2(DEPTH + 1)
)
(
	// Clock, reset, registers
	input wire logic          mclk,
	input wire logic          sys_rst,
	input reg_req_t           reg_req,
	input wire logic [7:0]    reg_rdata_r,
	// Buffer
	input wire logic [1:0]    buf_mode,
	input wire logic          smp_ready_r,
	input wire logic          rd_valid_r,
	input wire logic [CW-1:0] sample_count,
	// Status
	input wire logic          wmrk_flag_r,
	input wire logic          queue_overflow_flag_r,
	input wire logic          gate_clear_r,
	input wire logic          aslp_restart_r,
	input wire logic          sleep_permit_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic fl;
	assign fl = reg_req.wr && reg_req.addr == BUF_CFG2_ADDR && reg_req.wdata[FLUSH_BIT];
	logic [THRESH_W-1:0] thr_seen;
	// Shadow of the threshold, so the flag is judged from the bus alone
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			thr_seen <= '0;
		else if (reg_req.wr && reg_req.addr == BUF_CFG2_ADDR)
			thr_seen <= reg_req.wdata[THRESH_LSB +: THRESH_W];
	end
	// Two cycles: the flush bit is registered before it empties the buffer
	chk_flush_empty: assert property (
		fl |-> ##2 sample_count == 0 && !wmrk_flag_r && !queue_overflow_flag_r)
		else $error("flush left samples or flags");
	chk_flush_gate: assert property (fl |-> ##2 gate_clear_r)
		else $error("flush did not clear gate state");
	chk_flush_hidden: assert property (
		reg_req.rd && reg_req.addr == BUF_CFG2_ADDR |=> !reg_rdata_r[FLUSH_BIT])
		else $error("flush bit seen by a read");
	chk_mode_off: assert property ((buf_mode == MODE_OFF) [*2] |->
		sample_count == 0 && !wmrk_flag_r && !queue_overflow_flag_r && gate_clear_r)
		else $error("disabled buffer not cleared");
	chk_off_sleep: assert property ((buf_mode == MODE_OFF) [*2] |-> sleep_permit_r)
		else $error("selector acted outside stream or stop");
	chk_zero_thresh: assert property (
		wmrk_flag_r |-> sample_count != 0 && $past(thr_seen) != 0)
		else $error("watermark flag with zero threshold");
	chk_wmrk_level: assert property (
		wmrk_flag_r == ($past(thr_seen) != 0 && sample_count >= $past(thr_seen)))
		else $error("watermark flag disagrees with fill level");
	chk_restart_flags: assert property (
		aslp_restart_r |-> !wmrk_flag_r && !queue_overflow_flag_r)
		else $error("sleep timer restart with flags pending");
	chk_trig_hold: assert property (
		buf_mode == MODE_TRIG && queue_overflow_flag_r |-> !smp_ready_r)
		else $error("sample taken after capture ended");
	cover property (fl);
	cover property (rd_valid_r);
	cover property (buf_mode == MODE_TRIG && queue_overflow_flag_r);
endmodule

bind sample_buffer_config_control sample_buffer_config_control_assertions #(.DEPTH(DEPTH))
	i_chk (.mclk, .sys_rst, .reg_req, .reg_rdata_r, .buf_mode, .smp_ready_r, .rd_valid_r,
	.sample_count, .wmrk_flag_r, .queue_overflow_flag_r, .gate_clear_r, .aslp_restart_r,
	.sleep_permit_r);

//--- verif/sample_source_model.sv
`timescale 1ns/1ps
module sample_source_model
	import sample_buffer_pkg::*;
(
	// Control
	input  wire logic mclk,
	input  wire logic slow,
	input  wire integer tgt,
	// Sample link
	input  wire logic smp_ready_r,
	output logic      smp_valid = 1'b0,
	output sample_t   smp_data = '0,
	output int        sent = 0
);
	logic tk = 1'b0;
	logic ph = 1'b0;
	always @(posedge mclk)
		tk = smp_valid && smp_ready_r;
	// Offer held until taken; idle data inverts so stale words never match
	always @(negedge mclk)
	begin
		if (tk)
			sent = sent + 1;
		ph = !ph;
		smp_valid = sent < tgt && ((smp_valid && !tk) || !slow || ph);
		smp_data = smp_valid ? {AXIS_W'(sent), ~AXIS_W'(sent), AXIS_W'(sent)} : ~smp_data;
	end
endmodule

//--- verif/tb_sample_buffer_config_control.sv
`timescale 1ns/1ps
module tb_sample_buffer_config_control
	import sample_buffer_pkg::*;
();
	logic       mclk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ce = 1'b1;
	logic       trig_in = 1'b0;
	logic       rd_req = 1'b0;
	logic       slow = 1'b0;
	logic [1:0] buf_mode = MODE_OFF;
	reg_req_t   reg_req = '0;
	sample_t    smp_data, rd_data_r;
	logic [7:0] reg_rdata_r;
	logic [5:0] sample_count;
	logic       smp_valid, smp_ready_r, rd_valid_r, gate_clear_r, aslp_restart_r;
	logic       wmrk_flag_r, queue_overflow_flag_r, sleep_permit_r;
	int         tgt = 0, sent, mismatches = 0, n_checks = 0, n_gate = 0, n_rst = 0, b, bg;

	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if (gate_clear_r === 1'b1)
			n_gate++;
		if (aslp_restart_r === 1'b1)
			n_rst++;
	end

	sample_buffer_config_control i_dut (.mclk, .sys_rst, .ce, .reg_req, .reg_rdata_r,
		.buf_mode, .trig_in, .smp_valid, .smp_ready_r, .smp_data, .rd_req, .rd_valid_r,
		.rd_data_r, .sample_count, .wmrk_flag_r, .queue_overflow_flag_r, .gate_clear_r,
		.aslp_restart_r, .sleep_permit_r);
	sample_source_model i_src (.mclk, .slow, .tgt, .smp_ready_r, .smp_valid, .smp_data, .sent);

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic st(input logic [5:0] c, input logic [2:0] f);
		chk({sample_count, wmrk_flag_r, queue_overflow_flag_r, sleep_permit_r}, {c, f});
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge mclk);
		reg_req = '{1'b1, 1'b0, BUF_CFG2_ADDR, d};
		@(negedge mclk);
		reg_req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk);
		reg_req = '0;
		chk(reg_rdata_r, e);
	endtask

	task automatic feed(input int n);
		int k;
		k = 0;
		tgt = sent + n;
		while (sent < tgt && k < 100)
		begin
			@(negedge mclk);
			k++;
		end
		tgt = sent;
		repeat (3) @(negedge mclk);
	endtask

	task automatic pop(input logic v, input int k);
		@(negedge mclk);
		rd_req = 1'b1;
		@(negedge mclk);
		rd_req = 1'b0;
		chk(rd_valid_r, v);
		if (v)
			chk(rd_data_r, {AXIS_W'(k), ~AXIS_W'(k), AXIS_W'(k)});
	endtask

	task automatic final_report;
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		mismatches++;
		final_report();
	end

	initial
	begin
		repeat (10) @(negedge mclk);
		sys_rst = 1'b0;
		rd(BUF_CFG2_ADDR, 8'h00);
		rd(8'h28, 8'h00);
		buf_mode = MODE_STREAM;
		wr(8'h45);
		rd(BUF_CFG2_ADDR, 8'h45);
		slow = 1'b1;
		feed(4);
		slow = 1'b0;
		st(6'h04, 3'h0);
		feed(1);
		st(6'h05, 3'h5);
		b = n_rst;
		pop(1'b1, 0);
		// Restart pulse is counted one edge after it shows
		@(negedge mclk);
		chk(n_rst - b, 1);
		feed(1);
		bg = n_gate;
		b = n_rst;
		wr(8'hC5);
		rd(BUF_CFG2_ADDR, 8'h45);
		st(6'h00, 3'h0);
		chk(n_gate - bg, 1);
		chk(n_rst - b, 1);
		pop(1'b0, 0);
		wr(8'h05);
		feed(4);
		st(6'h04, 3'h1);
		feed(1);
		st(6'h05, 3'h5);
		wr(8'h00);
		// Flag follows a new threshold one edge after the write lands
		@(negedge mclk);
		st(6'h05, 3'h1);
		feed(28);
		st(6'h20, 3'h3);
		pop(1'b1, 7);
		buf_mode = MODE_OFF;
		wr(8'h45);
		st(6'h00, 3'h1);
		buf_mode = MODE_STOP;
		feed(40);
		st(6'h20, 3'h7);
		buf_mode = MODE_OFF;
		wr(8'h04);
		st(6'h00, 3'h1);
		buf_mode = MODE_TRIG;
		b = sent;
		feed(10);
		chk(sample_count, 6'h04);
		@(negedge mclk);
		trig_in = 1'b1;
		@(negedge mclk);
		trig_in = 1'b0;
		feed(40);
		chk({sample_count, queue_overflow_flag_r}, {6'h20, 1'b1});
		pop(1'b1, b + 6);
		final_report();
	end
endmodule
